/* pmr_defs.vh */
/*
  Constants for the power monitor register bank: register addresses,
  configuration field positions, reset values and start-up delay timing.
  Assumes a 100 MHz core clock and a 6-bit register address.

  // Behaviour
  // - Bus voltage result, 16 bits, address 5h
  // - Diagnostic flags and alerts, 16 bits, Bh
  // - Bus overvoltage threshold, 16 bits, address Eh
  // - Power over-limit threshold, 16 bits, 11h
  // - Identification register, 16 bits, address 3Eh
  // - Config bit 15 soft reset, self-clearing
  // - Config bit 14 clears energy and charge
  // - First conversion delayed code times 2 ms
  // - Config bit 4 always reads one
  // - Config bits 5 and 3-0 read zero
*/
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH

// ------------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------------
`define PMR_ADDR_DEV_CFG 6'h00
`define PMR_ADDR_CONV_CFG 6'h01
`define PMR_ADDR_BUS_V 6'h05
`define PMR_ADDR_TEMP 6'h06
`define PMR_ADDR_CURR 6'h07
`define PMR_ADDR_POWER 6'h08
`define PMR_ADDR_ENERGY 6'h09
`define PMR_ADDR_CHARGE 6'h0A
`define PMR_ADDR_DIAG 6'h0B
`define PMR_ADDR_CUR_OVER 6'h0C
`define PMR_ADDR_CUR_UNDER 6'h0D
`define PMR_ADDR_BUS_OVER 6'h0E
`define PMR_ADDR_BUS_UNDER 6'h0F
`define PMR_ADDR_TEMP_OVER 6'h10
`define PMR_ADDR_PWR_OVER 6'h11
`define PMR_ADDR_MAKER_ID 6'h3E

// ------------------------------------------------------------------
// Configuration fields
// ------------------------------------------------------------------
`define PMR_CFG_SOFT_RST 15
`define PMR_CFG_ACC_CLR 14
`define PMR_CFG_DLY_HI 13
`define PMR_CFG_DLY_LO 6
`define PMR_CFG_ONE_BIT 4
`define PMR_DIAG_SET_HI 15
`define PMR_DIAG_SET_LO 8

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PMR_RST_DEV_CFG 16'h0000
`define PMR_RST_CONV_CFG 16'hFB68
`define PMR_RST_LIMIT 16'h0000
`define PMR_RST_DIAG 16'h0000
`define PMR_RST_MAKER_ID 16'h5A5A

// ------------------------------------------------------------------
// Start-up delay timing
// ------------------------------------------------------------------
`define PMR_CLK_MHZ 100
`define PMR_DLY_STEP_MS 2
// 2 ms of the 100 MHz core clock, sized to the 18-bit tick counter
`define PMR_DLY_STEP_CYCLES 18'h30D40

`endif

/* pmr_register_bank.v */
/*
  Register bank of the power monitor: configuration, results,
  accumulators, diagnostics, limit thresholds and identification.
  Assumes the serial bus front end presents single-cycle read and write
  strobes on the core clock, and that measurement logic shares that clock.
*/
`include "pmr_defs.vh"

module pmr_register_bank #(
  parameter [17:0] DLY_STEP_CYCLES = `PMR_DLY_STEP_CYCLES,
  // Identification value is arbitrary
  parameter [15:0] MAKER_ID = `PMR_RST_MAKER_ID
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // Register access from the serial bus front end
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [5:0] i_addr,
  input wire [15:0] i_wdata,
  output reg [39:0] o_rdata,
  output reg o_rvalid,
  // Measurement results
  input wire i_meas_valid,
  input wire [15:0] i_bus_voltage,
  input wire [15:0] i_die_temp,
  input wire [15:0] i_current,
  input wire [23:0] i_power,
  // Accumulator increments
  input wire i_acc_valid,
  input wire [39:0] i_energy_inc,
  input wire [39:0] i_charge_inc,
  // Diagnostic flag events
  input wire [7:0] i_diag_set,
  // Configuration towards converter and alert logic
  output reg [15:0] o_conv_cfg,
  output reg [15:0] o_diag_cfg,
  output reg [15:0] o_cur_over,
  output reg [15:0] o_cur_under,
  output reg [15:0] o_bus_over,
  output reg [15:0] o_bus_under,
  output reg [15:0] o_temp_over,
  output reg [15:0] o_pwr_over,
  // Status
  output reg o_conv_enable,
  output reg o_soft_reset
);

  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  // Soft reset lasts one cycle and returns the whole bank to default
  wire rst = i_sys_rst | o_soft_reset;
  wire wr_cfg = i_wr_en && (i_addr == `PMR_ADDR_DEV_CFG);

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_soft_reset <= 1'b0;
    end else begin
      // Bit is never stored, so it reads back zero: self-clearing
      o_soft_reset <= wr_cfg & i_wdata[`PMR_CFG_SOFT_RST];
    end
  end

  // ----------------------------------------------------------------
  // Configuration and limit registers
  // ----------------------------------------------------------------
  reg acc_clr_q;
  reg [7:0] dly_code_q;

  always @(posedge i_core_clk) begin
    if (rst) begin
      acc_clr_q <= 1'b0;
      dly_code_q <= 8'h00;
      o_conv_cfg <= `PMR_RST_CONV_CFG;
      o_cur_over <= `PMR_RST_LIMIT;
      o_cur_under <= `PMR_RST_LIMIT;
      o_bus_over <= `PMR_RST_LIMIT;
      o_bus_under <= `PMR_RST_LIMIT;
      o_temp_over <= `PMR_RST_LIMIT;
      o_pwr_over <= `PMR_RST_LIMIT;
    end else if (i_wr_en) begin
      case (i_addr)
        `PMR_ADDR_DEV_CFG: begin
          acc_clr_q <= i_wdata[`PMR_CFG_ACC_CLR];
          dly_code_q <= i_wdata[`PMR_CFG_DLY_HI:`PMR_CFG_DLY_LO];
        end
        `PMR_ADDR_CONV_CFG: begin
          o_conv_cfg <= i_wdata;
        end
        `PMR_ADDR_CUR_OVER: begin
          o_cur_over <= i_wdata;
        end
        `PMR_ADDR_CUR_UNDER: begin
          o_cur_under <= i_wdata;
        end
        `PMR_ADDR_BUS_OVER: begin
          o_bus_over <= i_wdata;
        end
        `PMR_ADDR_BUS_UNDER: begin
          o_bus_under <= i_wdata;
        end
        `PMR_ADDR_TEMP_OVER: begin
          o_temp_over <= i_wdata;
        end
        `PMR_ADDR_PWR_OVER: begin
          o_pwr_over <= i_wdata;
        end
        default: begin
          // Results, identity and unlisted addresses keep their contents
          acc_clr_q <= acc_clr_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic flags and alert settings
  // ----------------------------------------------------------------
  // Upper byte is host settings, lower byte sticky flags, write one to
  // clear; a new event in the clearing cycle wins
  wire [7:0] diag_flags;
  wire wr_diag = i_wr_en && (i_addr == `PMR_ADDR_DIAG);
  wire [7:0] diag_clr = wr_diag ? i_wdata[7:0] : 8'h00;

  always @(posedge i_core_clk) begin
    if (rst) begin
      o_diag_cfg <= `PMR_RST_DIAG;
    end else if (wr_diag) begin
      o_diag_cfg <= {i_wdata[`PMR_DIAG_SET_HI:`PMR_DIAG_SET_LO], 8'h00};
    end
  end

  // One flop per flag, so each event source stands on its own;
  // the set arm comes first so a racing clear cannot lose an event
  genvar g_bit;
  generate
    for (g_bit = 0; g_bit < 8; g_bit = g_bit + 1) begin : g_diag_flag
      reg flag_q;

      always @(posedge i_core_clk) begin
        if (rst) begin
          flag_q <= 1'b0;
        end else if (i_diag_set[g_bit]) begin
          // Set beats clear in the same cycle
          flag_q <= 1'b1;
        end else if (diag_clr[g_bit]) begin
          flag_q <= 1'b0;
        end
      end

      assign diag_flags[g_bit] = flag_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Measurement results and accumulators
  // ----------------------------------------------------------------
  reg [15:0] bus_v_q;
  reg [15:0] temp_q;
  reg [15:0] curr_q;
  reg [23:0] power_q;
  reg [39:0] energy_q;
  reg [39:0] charge_q;

  always @(posedge i_core_clk) begin
    if (rst) begin
      bus_v_q <= 16'h0000;
      temp_q <= 16'h0000;
      curr_q <= 16'h0000;
      power_q <= 24'h000000;
    end else if (i_meas_valid) begin
      bus_v_q <= i_bus_voltage;
      temp_q <= {i_die_temp[15:4], 4'h0};
      curr_q <= i_current;
      power_q <= i_power;
    end
  end

  // Clear is held while the bit stays set, so no increment slips in
  always @(posedge i_core_clk) begin
    if (rst || acc_clr_q) begin
      energy_q <= 40'h0000000000;
      charge_q <= 40'h0000000000;
    end else if (i_acc_valid) begin
      energy_q <= energy_q + i_energy_inc;
      charge_q <= charge_q + i_charge_inc;
    end
  end

  // ----------------------------------------------------------------
  // Start-up conversion delay
  // ----------------------------------------------------------------
  // A configuration write restarts the wait with the new code, so the
  // delay applies to the first conversion after it; code 0 starts at once
  // Limitation: steps longer than 18 bits of ticks need a wider counter
  reg [17:0] tick_q;
  reg [7:0] step_q;

  always @(posedge i_core_clk) begin
    if (rst) begin
      tick_q <= 18'h00000;
      step_q <= 8'h00;
      o_conv_enable <= 1'b0;
    end else if (wr_cfg) begin
      // Restart the count from zero for the code written now
      tick_q <= 18'h00000;
      step_q <= 8'h00;
      o_conv_enable <= 1'b0;
    end else if (!o_conv_enable) begin
      if (step_q == dly_code_q) begin
        o_conv_enable <= 1'b1;
      end else if (tick_q == DLY_STEP_CYCLES - 18'h00001) begin
        tick_q <= 18'h00000;
        step_q <= step_q + 8'h01;
      end else begin
        tick_q <= tick_q + 18'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  reg [39:0] rd_mux;

  always @* begin
    rd_mux = 40'h0000000000;
    case (i_addr)
      `PMR_ADDR_DEV_CFG: begin
        // Bit 15 self-clears, bits 5 and 3-0 zero, bit 4 one
        rd_mux[`PMR_CFG_ACC_CLR] = acc_clr_q;
        rd_mux[`PMR_CFG_DLY_HI:`PMR_CFG_DLY_LO] = dly_code_q;
        rd_mux[`PMR_CFG_ONE_BIT] = 1'b1;
        // Bits 5 and 3-0 keep the zero set above
      end
      `PMR_ADDR_CONV_CFG: begin
        rd_mux[15:0] = o_conv_cfg;
      end
      `PMR_ADDR_BUS_V: begin
        rd_mux[15:0] = bus_v_q;
      end
      `PMR_ADDR_TEMP: begin
        rd_mux[15:0] = temp_q;
      end
      `PMR_ADDR_CURR: begin
        rd_mux[15:0] = curr_q;
      end
      `PMR_ADDR_POWER: begin
        rd_mux[23:0] = power_q;
      end
      `PMR_ADDR_ENERGY: begin
        rd_mux = energy_q;
      end
      `PMR_ADDR_CHARGE: begin
        rd_mux = charge_q;
      end
      `PMR_ADDR_DIAG: begin
        rd_mux[15:0] = o_diag_cfg | {8'h00, diag_flags};
      end
      `PMR_ADDR_CUR_OVER: begin
        rd_mux[15:0] = o_cur_over;
      end
      `PMR_ADDR_CUR_UNDER: begin
        rd_mux[15:0] = o_cur_under;
      end
      `PMR_ADDR_BUS_OVER: begin
        rd_mux[15:0] = o_bus_over;
      end
      `PMR_ADDR_BUS_UNDER: begin
        rd_mux[15:0] = o_bus_under;
      end
      `PMR_ADDR_TEMP_OVER: begin
        rd_mux[15:0] = o_temp_over;
      end
      `PMR_ADDR_PWR_OVER: begin
        rd_mux[15:0] = o_pwr_over;
      end
      `PMR_ADDR_MAKER_ID: begin
        rd_mux[15:0] = MAKER_ID;
      end
      default: begin
        // Unlisted addresses read zero
        rd_mux = 40'h0000000000;
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (rst) begin
      o_rdata <= 40'h0000000000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= rd_mux;
      end
    end
  end

endmodule // pmr_register_bank

/* pmr_register_bank_props.sv */
/* Port assertions for the register bank.
   Bound onto pmr_register_bank; single clock domain. */
`include "pmr_defs.vh"
module pmr_rb_props #(
  parameter [15:0] MAKER_ID = 16'h0000
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // Bus and inputs
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [5:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_meas_valid,
  input wire [15:0] i_bus_voltage,
  input wire [7:0] i_diag_set,
  // Outputs
  input wire [39:0] o_rdata,
  input wire o_rvalid,
  input wire [15:0] o_conv_cfg,
  input wire [15:0] o_bus_over,
  input wire [15:0] o_pwr_over,
  input wire o_conv_enable,
  input wire o_soft_reset
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Requests in the soft reset cycle are lost, except a config write with bit 15 set, which repeats the soft reset
  wire rd_ok = i_rd_en && !o_soft_reset;
  wire wr_ok = i_wr_en && !o_soft_reset;
  // ----------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------
  sequence s_meas;
    i_meas_valid ##1 !i_meas_valid;
  endsequence
  sequence s_rd(logic [5:0] a);
    rd_ok && i_addr == a;
  endsequence
  property p_rvalid;
    rd_ok |=> o_rvalid;
  endproperty
  property p_idle;
    !i_rd_en |=> !o_rvalid;
  endproperty
  property p_bus_voltage_result;
    s_meas ##1 s_rd(`PMR_ADDR_BUS_V)
      |=> o_rdata[15:0] == $past(i_bus_voltage, 3);
  endproperty
  property p_diag;
    i_diag_set[0] ##2 s_rd(`PMR_ADDR_DIAG) |=> o_rdata[0];
  endproperty
  property p_bus_over;
    wr_ok && i_addr == `PMR_ADDR_BUS_OVER |=> o_bus_over == $past(i_wdata);
  endproperty
  property p_pwr_over;
    wr_ok && i_addr == `PMR_ADDR_PWR_OVER |=> o_pwr_over == $past(i_wdata);
  endproperty
  property p_id;
    s_rd(`PMR_ADDR_MAKER_ID) |=> o_rdata == {24'h000000, MAKER_ID};
  endproperty
  property p_soft;
    wr_ok && i_addr == `PMR_ADDR_DEV_CFG && i_wdata[15] |=> o_soft_reset
      ##1 (!o_soft_reset && o_conv_cfg == 16'hFB68 && o_bus_over == 16'h0);
  endproperty
  property p_conv_en;
    $fell(i_sys_rst) |-> ##[1:3] o_conv_enable;
  endproperty
  property p_dly_restart;
    wr_ok && i_addr == `PMR_ADDR_DEV_CFG && !i_wdata[15] |=> !o_conv_enable;
  endproperty
  property p_cfg_rd;
    s_rd(`PMR_ADDR_DEV_CFG) |=> o_rdata[5:0] == 6'h10 && !o_rdata[15];
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  a_idle: assert property (p_idle) else $error("spurious read valid");
  a_bus_voltage_result: assert property (p_bus_voltage_result) else $error("bus voltage wrong");
  a_diag: assert property (p_diag) else $error("diag flag lost");
  a_bus_over: assert property (p_bus_over) else $error("bus limit");
  a_pwr_over: assert property (p_pwr_over) else $error("power_over_threshold");
  a_id: assert property (p_id) else $error("id value wrong");
  a_soft: assert property (p_soft) else $error("soft reset wrong");
  a_conv_en: assert property (p_conv_en) else $error("no start");
  a_cfg_rd: assert property (p_cfg_rd) else $error("cfg bits");
  a_dly_restart: assert property (p_dly_restart) else $error("no wait");
endmodule // pmr_rb_props

bind pmr_register_bank pmr_rb_props #(.MAKER_ID(MAKER_ID)) u_props (.*);

/* pmr_host_model.sv */
/* Host model driving the register bus.
   Assumes the bench calls its tasks; drives at the falling edge. */
module pmr_host_model (
  // Clock
  input wire i_core_clk,
  // Bus towards the bank
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [5:0] o_addr,
  output logic [15:0] o_wdata,
  input wire [39:0] i_rdata,
  input wire i_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 6'h3F;
    o_wdata = 16'h0000;
  end
  // Idle lines invert so stale values are never trusted
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_addr = a; // Only mapped addresses
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_core_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [39:0] d,
                    output logic v);
    @(negedge i_core_clk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_core_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule // pmr_host_model

/* pmr_register_bank_tb_top.sv */
/* Self-checking bench for the register bank.
   Assumes 100 MHz clock and a shortened start-up step. */
`include "pmr_defs.vh"
module pmr_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] ID = 16'hC3A5; // Arbitrary identification value
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wr_en, i_rd_en, o_rvalid, o_conv_enable, o_soft_reset;
  logic i_meas_valid = 1'b0;
  logic i_acc_valid = 1'b0;
  logic [5:0] i_addr;
  logic [15:0] i_wdata, o_bus_over, o_pwr_over;
  logic [15:0] o_conv_cfg, o_diag_cfg, o_cur_over, o_cur_under;
  logic [15:0] o_bus_under, o_temp_over;
  logic [15:0] i_bus_voltage = 16'h0000;
  logic [39:0] i_energy_inc = 40'h5;
  logic [39:0] i_charge_inc = 40'h7;
  logic [7:0] i_diag_set = 8'h00;
  logic [39:0] o_rdata;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  pmr_register_bank #(.DLY_STEP_CYCLES(18'h4), .MAKER_ID(ID)) u_dut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_meas_valid(i_meas_valid),
    .i_bus_voltage(i_bus_voltage), .i_die_temp(16'hFFFF),
    .i_current(16'h1234), .i_power(24'h36EE80), .i_acc_valid(i_acc_valid),
    .i_energy_inc(i_energy_inc), .i_charge_inc(i_charge_inc),
    .i_diag_set(i_diag_set), .o_conv_cfg(o_conv_cfg),
    .o_diag_cfg(o_diag_cfg), .o_cur_over(o_cur_over),
    .o_cur_under(o_cur_under), .o_bus_over(o_bus_over),
    .o_bus_under(o_bus_under), .o_temp_over(o_temp_over),
    .o_pwr_over(o_pwr_over),
    .o_conv_enable(o_conv_enable), .o_soft_reset(o_soft_reset));
  pmr_host_model u_host (
    .i_core_clk(i_core_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wdata(i_wdata), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid));
  // ----------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [39:0] e);
    logic [39:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk(40'h1, {39'h0, v});
    chk(e, d);
  endtask
  task automatic acc_pulse();
    @(negedge i_core_clk);
    i_acc_valid = 1'b1;
    @(negedge i_core_clk);
    i_acc_valid = 1'b0;
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_defaults();
    rchk(`PMR_ADDR_DEV_CFG, 40'h10);
    rchk(`PMR_ADDR_CONV_CFG, 40'hFB68);
    rchk(`PMR_ADDR_BUS_OVER, 40'h0);
    rchk(`PMR_ADDR_MAKER_ID, {24'h0, ID});
    rchk(6'h20, 40'h0);
  endtask
  task automatic t_limits();
    for (int i = 0; i < 6; i++)
      u_host.wr(6'h0C + i[5:0], 16'hA500 + i[15:0]);
    for (int i = 0; i < 6; i++)
      rchk(6'h0C + i[5:0], {24'h0, 16'hA500 + i[15:0]});
    chk(40'hA502, {24'h0, o_bus_over});
    chk(40'hA505, {24'h0, o_pwr_over});
    chk(40'hA500, {24'h0, o_cur_over});
    chk(40'hA501, {24'h0, o_cur_under});
    chk(40'hA503, {24'h0, o_bus_under});
    chk(40'hA504, {24'h0, o_temp_over});
  endtask
  task automatic t_readonly();
    @(negedge i_core_clk);
    i_bus_voltage = 16'h3C00;
    i_meas_valid = 1'b1;
    @(negedge i_core_clk);
    i_meas_valid = 1'b0;
    i_bus_voltage = 16'hC3FF;
    rchk(`PMR_ADDR_BUS_V, 40'h3C00);
    rchk(`PMR_ADDR_TEMP, 40'hFFF0);
    rchk(`PMR_ADDR_CURR, 40'h1234);
    rchk(`PMR_ADDR_POWER, 40'h36EE80);
    u_host.wr(`PMR_ADDR_BUS_V, 16'h1234);
    u_host.wr(`PMR_ADDR_MAKER_ID, 16'h0000);
    rchk(`PMR_ADDR_BUS_V, 40'h3C00);
    rchk(`PMR_ADDR_MAKER_ID, {24'h0, ID});
  endtask
  task automatic t_accum();
    u_host.wr(`PMR_ADDR_DEV_CFG, 16'h7FEF);
    rchk(`PMR_ADDR_DEV_CFG, 40'h7FD0);
    acc_pulse();
    rchk(`PMR_ADDR_ENERGY, 40'h0);
    u_host.wr(`PMR_ADDR_DEV_CFG, 16'h0000);
    acc_pulse();
    rchk(`PMR_ADDR_ENERGY, 40'h5);
    rchk(`PMR_ADDR_CHARGE, 40'h7);
    u_host.wr(`PMR_ADDR_DEV_CFG, 16'h4000);
    rchk(`PMR_ADDR_ENERGY, 40'h0);
    rchk(`PMR_ADDR_CHARGE, 40'h0);
  endtask
  task automatic t_diag();
    @(negedge i_core_clk);
    i_diag_set = 8'h81;
    @(negedge i_core_clk);
    i_diag_set = 8'h00;
    rchk(`PMR_ADDR_DIAG, 40'h81);
    u_host.wr(`PMR_ADDR_DIAG, 16'hA501);
    rchk(`PMR_ADDR_DIAG, 40'hA580);
    chk(40'hA500, {24'h0, o_diag_cfg});
    fork
      u_host.wr(`PMR_ADDR_DIAG, 16'hA502);
      begin
        @(negedge i_core_clk);
        i_diag_set = 8'h02;
        @(negedge i_core_clk);
        i_diag_set = 8'h00;
      end
    join
    rchk(`PMR_ADDR_DIAG, 40'hA582);
  endtask
  task automatic t_soft();
    u_host.wr(`PMR_ADDR_CONV_CFG, 16'h1234);
    chk(40'h1234, {24'h0, o_conv_cfg});
    u_host.wr(`PMR_ADDR_DEV_CFG, 16'h8000);
    chk(40'h1, {39'h0, o_soft_reset});
    @(negedge i_core_clk);
    chk(40'h0, {39'h0, o_soft_reset});
    chk(40'hFB68, {24'h0, o_conv_cfg});
    rchk(`PMR_ADDR_BUS_OVER, 40'h0);
    rchk(`PMR_ADDR_DEV_CFG, 40'h10);
    rchk(`PMR_ADDR_CONV_CFG, 40'hFB68);
    rchk(`PMR_ADDR_DIAG, 40'h0);
    chk(40'h1, {39'h0, o_conv_enable});
  endtask
  // Code 2 with a 4-cycle step: held off 8 cycles, on at the ninth edge
  task automatic t_delay();
    u_host.wr(`PMR_ADDR_DEV_CFG, 16'h0080);
    chk(40'h0, {39'h0, o_conv_enable});
    repeat (8) @(negedge i_core_clk);
    chk(40'h0, {39'h0, o_conv_enable});
    @(negedge i_core_clk);
    chk(40'h1, {39'h0, o_conv_enable});
    rchk(`PMR_ADDR_DEV_CFG, 40'h90);
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk(40'h1, {39'h0, o_conv_enable});
    t_defaults();
    t_limits();
    t_readonly();
    t_accum();
    t_diag();
    t_soft();
    t_delay();
    end_sim();
  end
endmodule // pmr_register_bank_tb_top
